/* hdl/security_config_reg_cmd_pkg.sv */
// constants and types for the security, backdoor key and margin command sequencer
// Overview of operation
// RULE_01: unsecure command 0x0B erases both arrays, verifies, releases security only on pass
// RULE_02: failed unsecure verify sets verify error, security left unchanged
// RULE_03: host writes no flash register while unsecure runs with complete flag low
// RULE_04: host launches by clearing complete flag; controller sets it again when done
// RULE_05: unsecure launched with word index other than 000 gives access error
// RULE_06: command not allowed in present mode gives access error
// RULE_07: unsecure with any protected region sets protection violation
// RULE_08: unsecure verify sets error flag, and second flag for uncorrectable errors
// RULE_09: backdoor key command 0x0C runs only when key enable field equals 10
// RULE_10: key access not enabled gives access error, no key compare
// RULE_11: four key words from indices 001 to 100 compared with stored key
// RULE_12: all key words matching releases security
// RULE_13: mismatch keeps security, access error, later key commands abort until reset
// RULE_14: backdoor key launched with word index other than 100 gives access error
// RULE_15: host never runs key command from the block holding the stored key
// RULE_16: margin command 0x0D takes block from word 000, setting from word 001
// RULE_17: data array margin hits data reads only; program array margin hits both
// RULE_18: setting 0000 normal, 0001 user level 1, 0002 user level 0
// RULE_19: invalid margin setting or word index other than 001 gives access error
// RULE_20: level 1 margins toward erased state, level 0 toward programmed state
// RULE_21: mismatch lockout latch cleared only by reset
// RULE_22: launch clears access, protection and verify flags before evaluation
package security_config_reg_cmd_pkg;
    localparam int WORD_W = 16;
    localparam int IDX_W = 3;
    localparam int ADDR_W = 4;
    // register offsets on the plain port
    localparam logic [3:0] OFS_STAT = 4'h0;
    localparam logic [3:0] OFS_IDX = 4'h1;
    localparam logic [3:0] OFS_PARAM = 4'h2;
    localparam logic [3:0] OFS_SEC = 4'h3;
    localparam logic [3:0] OFS_MARGIN = 4'h4;
    // status field positions
    localparam int ST_CMPL = 7;
    localparam int ST_ACC = 5;
    localparam int ST_PROT = 4;
    localparam int ST_VERR = 1;
    localparam int ST_VUNC = 0;
    // security config field positions and reset
    localparam int SEC_BACKDOOR_KEY_ENABLE_LO = 6;
    localparam int SEC_UNLOCK = 0;
    localparam logic [7:0] SEC_RST = 8'h00;
    localparam logic [1:0] BACKDOOR_KEY_ENABLE_ON = 2'h2;
    // command codes
    localparam logic [7:0] CMD_UNSECURE = 8'h0B;
    localparam logic [7:0] CMD_BACKDOOR = 8'h0C;
    localparam logic [7:0] CMD_MARGIN = 8'h0D;
    // last word index each command requires, then first key word index and key count
    localparam logic [2:0] IDX_UNSECURE = 3'h0;
    localparam logic [2:0] IDX_BACKDOOR = 3'h4;
    localparam logic [2:0] IDX_MARGIN = 3'h1;
    localparam logic [2:0] IDX_KEY0 = 3'h1;
    localparam int N_KEYS = 4;
    // margin encodings
    localparam logic [15:0] MRG_NORMAL = 16'h0000;
    localparam logic [15:0] MRG_USER1 = 16'h0001;
    localparam logic [15:0] MRG_USER0 = 16'h0002;
    // block select in word 000, bit 0: 0 program array, 1 data array
    localparam int BLK_BIT = 0;
    localparam logic [1:0] LVL_NORMAL = 2'h0;
    localparam logic [1:0] LVL_ERASED = 2'h1;
    localparam logic [1:0] LVL_PROGRAMMED = 2'h2;
    localparam logic [7:0] STAT_RST = 8'h80;
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_EVAL = 6'h02,
        S_ERASE = 6'h04,
        S_VERIFY = 6'h08,
        S_KEY = 6'h10,
        S_DONE = 6'h20
    } seq_state_t;
endpackage

/* hdl/security_config_reg_cmd_seq.sv */
// command sequencer for unsecure, backdoor key check and user margin commands
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module security_config_reg_cmd_seq #(
    parameter int ERASE_CYCLES = 64
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [security_config_reg_cmd_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [security_config_reg_cmd_pkg::WORD_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [security_config_reg_cmd_pkg::WORD_W-1:0] RDATA_O,
    input wire logic [7:0] SEC_CFG_I,
    input wire logic [security_config_reg_cmd_pkg::N_KEYS*security_config_reg_cmd_pkg::WORD_W-1:0] STORED_KEY_I,
    input wire logic PROTECT_ANY_I,
    input wire logic [2:0] MODE_DENY_I,
    output logic ARRAY_ERASE_O,
    input wire logic ERASE_DONE_I,
    input wire logic VERIFY_FAIL_I,
    input wire logic VERIFY_UNCORR_I,
    output logic SECURE_RELEASED_O,
    output logic [1:0] PROG_MARGIN_O,
    output logic [1:0] DATA_MARGIN_O,
    output logic CMD_COMPLETE_O
);
    import security_config_reg_cmd_pkg::*;

    initial begin
        if (ERASE_CYCLES < 1) $error("erase timeout must be positive");
    end

    seq_state_t state_q, state_d;
    logic cmd_complete_flag_q;
    logic access_error_flag_q;
    logic protect_violation_flag_q;
    logic verify_error_flag_q;
    logic verify_uncorrectable_flag_q;
    logic [IDX_W-1:0] cmd_word_index_q;
    logic [7:0] security_config_reg_q;
    logic unlocked_q;
    logic lockout_q;
    logic [1:0] prog_margin_q;
    logic [1:0] data_margin_q;
    logic [15:0] rdata_q;
    logic [15:0] word0_q;
    logic [15:0] word1_q;
    logic [2:0] key_idx_q;
    logic key_bad_q;
    logic erase_q;
    logic [31:0] erase_cnt_q;

    // bus decode
    wire wr_stat = WR_I && (ADDR_I == OFS_STAT);
    wire wr_idx = WR_I && (ADDR_I == OFS_IDX);
    wire wr_param = WR_I && (ADDR_I == OFS_PARAM);
    wire wr_sec = WR_I && (ADDR_I == OFS_SEC);
    wire rd_param = RD_I && (ADDR_I == OFS_PARAM);

    // launch: writing one to the complete bit clears it, as on the flag's w1c convention
    wire launch = wr_stat && WDATA_I[ST_CMPL] && cmd_complete_flag_q && (state_q == S_IDLE); // RULE_04
    // stray register writes while busy are dropped; host must not issue them
    wire host_wr_ok = cmd_complete_flag_q; // RULE_03

    // parameter buffer, read port doubles as key walker and host read
    logic [IDX_W-1:0] ram_raddr;
    logic [WORD_W-1:0] ram_rdata;

    assign ram_raddr = (state_q == S_KEY) ? key_idx_q : cmd_word_index_q;
    security_config_reg_param_ram #(
        .DEPTH(8),
        .AW(IDX_W),
        .W(WORD_W)
    ) u_param (
        .clk_i(CLK_I),
        .we_i(wr_param && host_wr_ok),
        .waddr_i(cmd_word_index_q),
        .wdata_i(WDATA_I),
        .raddr_i(ram_raddr),
        .rdata_o(ram_rdata)
    );

    // shadow copies of words 000 and 001 so evaluation needs no extra read cycles
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            word0_q <= 16'h0000;
            word1_q <= 16'h0000;
        end else if (wr_param && host_wr_ok) begin
            if (cmd_word_index_q == 3'h0) begin
                word0_q <= WDATA_I;
            end
            if (cmd_word_index_q == 3'h1) begin
                word1_q <= WDATA_I;
            end
        end
    end

    // command decode
    wire [7:0] cmd_code = word0_q[15:8];
    wire is_unsec = (cmd_code == CMD_UNSECURE);
    wire is_key = (cmd_code == CMD_BACKDOOR);
    wire is_margin = (cmd_code == CMD_MARGIN);

    wire [1:0] backdoor_key_enable = security_config_reg_q[SEC_BACKDOOR_KEY_ENABLE_LO +: 2];
    wire mode_deny = (is_unsec && MODE_DENY_I[0]) || (is_key && MODE_DENY_I[1]) ||
                     (is_margin && MODE_DENY_I[2]); // RULE_06
    wire unsec_acc = is_unsec && (cmd_word_index_q != IDX_UNSECURE); // RULE_05
    wire key_acc = is_key && ((cmd_word_index_q != IDX_BACKDOOR) ||
                   (backdoor_key_enable != BACKDOOR_KEY_ENABLE_ON) || lockout_q); // RULE_09 RULE_10 RULE_13 RULE_14
    wire margin_valid = (word1_q == MRG_NORMAL) || (word1_q == MRG_USER1) || (word1_q == MRG_USER0); // RULE_18
    wire margin_acc = is_margin && ((cmd_word_index_q != IDX_MARGIN) || !margin_valid); // RULE_19
    wire unknown_acc = !(is_unsec || is_key || is_margin);
    wire eval_acc = mode_deny || unsec_acc || key_acc || margin_acc || unknown_acc;
    wire eval_prot = is_unsec && PROTECT_ANY_I; // RULE_07

    wire [1:0] new_level = (word1_q == MRG_USER1) ? LVL_ERASED :
                           (word1_q == MRG_USER0) ? LVL_PROGRAMMED : LVL_NORMAL; // RULE_20
    wire blk_data = word0_q[BLK_BIT];

    // stored key word for the current compare step (read data lags key_idx_q by one)
    wire [2:0] key_prev = key_idx_q - 3'h1;
    wire [1:0] key_sel = 2'(key_prev - IDX_KEY0);
    wire [WORD_W-1:0] key_ref = STORED_KEY_I[key_sel*WORD_W +: WORD_W];
    wire key_step_bad = (ram_rdata != key_ref); // RULE_11
    wire key_cmp_live = (state_q == S_KEY) && (key_idx_q != IDX_KEY0);
    wire key_last = key_cmp_live && (key_prev == IDX_BACKDOOR);
    wire key_mismatch = key_bad_q || key_step_bad;
    // timeout lets a silent array fall through to verify instead of hanging the sequencer
    wire erase_timeout = (erase_cnt_q == 32'(ERASE_CYCLES));

    // sequence
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (launch) begin
                    state_d = S_EVAL;
                end
            end
            S_EVAL: begin
                if (eval_acc || eval_prot) begin
                    state_d = S_DONE;
                end else if (is_unsec) begin
                    state_d = S_ERASE;
                end else if (is_key) begin
                    state_d = S_KEY;
                end else begin
                    state_d = S_DONE;
                end
            end
            S_ERASE: begin
                if (ERASE_DONE_I || erase_timeout) begin
                    state_d = S_VERIFY;
                end
            end
            S_VERIFY: begin
                state_d = S_DONE;
            end
            S_KEY: begin
                if (key_last) begin
                    state_d = S_DONE;
                end
            end
            S_DONE: begin
                state_d = S_IDLE;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // launch drops the flag; the done state raises it on success and failure alike
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cmd_complete_flag_q <= 1'b1;
        end else if (launch) begin
            cmd_complete_flag_q <= 1'b0; // RULE_04
        end else if (state_q == S_DONE) begin
            cmd_complete_flag_q <= 1'b1; // RULE_04
        end
    end

    // launch wipes old flags so the status shows only the newest command
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            access_error_flag_q <= 1'b0;
            protect_violation_flag_q <= 1'b0;
            verify_error_flag_q <= 1'b0;
            verify_uncorrectable_flag_q <= 1'b0;
        end else if (launch) begin
            access_error_flag_q <= 1'b0; // RULE_22
            protect_violation_flag_q <= 1'b0;
            verify_error_flag_q <= 1'b0;
            verify_uncorrectable_flag_q <= 1'b0;
        end else begin
            if (state_q == S_EVAL && eval_acc) begin
                access_error_flag_q <= 1'b1; // RULE_05 RULE_06 RULE_10 RULE_14 RULE_19
            end
            if (key_last && key_mismatch) begin
                access_error_flag_q <= 1'b1; // RULE_13
            end
            if (state_q == S_EVAL && eval_prot) begin
                protect_violation_flag_q <= 1'b1; // RULE_07
            end
            if (state_q == S_VERIFY && (VERIFY_FAIL_I || VERIFY_UNCORR_I)) begin
                verify_error_flag_q <= 1'b1; // RULE_02 RULE_08
            end
            if (state_q == S_VERIFY && VERIFY_UNCORR_I) begin
                verify_uncorrectable_flag_q <= 1'b1; // RULE_08
            end
        end
    end

    // word index and security config registers
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cmd_word_index_q <= 3'h0;
            security_config_reg_q <= SEC_RST;
        end else begin
            if (wr_idx && host_wr_ok) begin
                cmd_word_index_q <= WDATA_I[IDX_W-1:0];
            end
            if (wr_sec && host_wr_ok) begin
                security_config_reg_q <= WDATA_I[7:0];
            end
        end
    end

    // erase strobe held while the array erase runs; timeout guards a silent array
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            erase_q <= 1'b0;
            erase_cnt_q <= 32'h0;
        end else begin
            erase_q <= (state_d == S_ERASE); // RULE_01
            erase_cnt_q <= (state_q == S_ERASE) ? erase_cnt_q + 32'h1 : 32'h0;
        end
    end

    // key walk: address runs 001..101, compare trails by one cycle
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            key_idx_q <= 3'h0;
            key_bad_q <= 1'b0;
        end else if (state_q == S_EVAL) begin
            key_idx_q <= IDX_KEY0;
            key_bad_q <= 1'b0;
        end else if (state_q == S_KEY) begin
            key_idx_q <= key_idx_q + 3'h1;
            if (key_cmp_live && key_step_bad) begin
                key_bad_q <= 1'b1; // RULE_11
            end
        end
    end

    // security and lockout; lockout only reset clears
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            unlocked_q <= 1'b0;
            lockout_q <= 1'b0; // RULE_21
        end else begin
            if (state_q == S_VERIFY && !VERIFY_FAIL_I && !VERIFY_UNCORR_I) begin
                unlocked_q <= 1'b1; // RULE_01 RULE_02
            end
            if (key_last && !key_mismatch) begin
                unlocked_q <= 1'b1; // RULE_12
            end
            if (key_last && key_mismatch) begin
                lockout_q <= 1'b1; // RULE_13 RULE_21
            end
        end
    end

    // margin levels
    // an access error leaves both margins untouched
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            prog_margin_q <= LVL_NORMAL;
            data_margin_q <= LVL_NORMAL;
        end else if (state_q == S_EVAL && is_margin && !eval_acc) begin
            if (blk_data) begin
                data_margin_q <= new_level; // RULE_16 RULE_17
            end else begin
                prog_margin_q <= new_level; // RULE_16 RULE_17
            end
        end
    end

    // program array margin also governs data reads unless data margin set
    wire [1:0] data_eff = (data_margin_q != LVL_NORMAL) ? data_margin_q : prog_margin_q; // RULE_17

    // read mux; parameter reads come from the registered ram one cycle later
    wire [15:0] stat_word = {8'h00, cmd_complete_flag_q, 1'b0, access_error_flag_q,
                             protect_violation_flag_q, 2'b00, verify_error_flag_q,
                             verify_uncorrectable_flag_q};

    logic rd_param_q;
    wire [15:0] rd_mux = (ADDR_I == OFS_STAT) ? stat_word :
                         (ADDR_I == OFS_IDX) ? {13'h0, cmd_word_index_q} :
                         (ADDR_I == OFS_SEC) ? {8'h00, security_config_reg_q[7:1], unlocked_q} :
                         (ADDR_I == OFS_MARGIN) ? {8'h00, lockout_q, 1'b0, data_margin_q,
                                                   2'b00, prog_margin_q} : 16'h0000;
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            rdata_q <= 16'h0000;
            rd_param_q <= 1'b0;
        end else begin
            rd_param_q <= rd_param;
            rdata_q <= RD_I ? rd_mux : 16'h0000;
        end
    end

    // status ports are copies one cycle late, so each leaves a flip-flop
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            SECURE_RELEASED_O <= 1'b0;
            PROG_MARGIN_O <= LVL_NORMAL;
            DATA_MARGIN_O <= LVL_NORMAL;
            CMD_COMPLETE_O <= 1'b1;
        end else begin
            SECURE_RELEASED_O <= unlocked_q;
            PROG_MARGIN_O <= prog_margin_q;
            DATA_MARGIN_O <= data_eff;
            CMD_COMPLETE_O <= cmd_complete_flag_q;
        end
    end

    // erase strobe is already a flip-flop
    assign ARRAY_ERASE_O = erase_q;
    assign RDATA_O = rd_param_q ? ram_rdata : rdata_q;
endmodule
`default_nettype wire

/* hdl/security_config_reg_param_ram.sv */
// indexed command parameter buffer with registered read
`timescale 1ns/1ns
`default_nettype none
module security_config_reg_param_ram #(
    parameter int DEPTH = 8,
    parameter int AW = 3,
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [W-1:0] rdata_o
);
    logic [W-1:0] mem [DEPTH];
    initial begin
        if (DEPTH > (1 << AW)) $error("depth exceeds address range");
    end
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule
`default_nettype wire

/* verif/flash_array_model.sv */
// behavioural flash array answering erase and verify requests
`timescale 1ns/1ns
`default_nettype none
module flash_array_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic erase_i,
    input wire logic [1:0] fail_cfg_i,
    input wire logic [3:0] delay_i,
    output logic done_o,
    output logic fail_o,
    output logic unc_o
);
    logic [3:0] cnt_q;
    logic erase_q;
    logic win_q;
    logic tgl_q;
    wire logic win = (erase_q & ~erase_i) | win_q;
    assign done_o = erase_i && (cnt_q == delay_i);
    // verify results only hold just after erase; elsewhere they toggle so nothing can lean on them
    assign fail_o = win ? fail_cfg_i[0] : tgl_q;
    assign unc_o = win ? fail_cfg_i[1] : ~tgl_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
            erase_q <= 1'b0;
            win_q <= 1'b0;
            tgl_q <= 1'b0;
        end else begin
            cnt_q <= erase_i ? cnt_q + 4'h1 : 4'h0;
            erase_q <= erase_i;
            win_q <= erase_q & ~erase_i;
            tgl_q <= ~tgl_q;
        end
    end
endmodule
`default_nettype wire

/* verif/flash_security_margin_commands_test.sv */
// self-checking bench for the security, key and margin command sequencer
`timescale 1ns/1ns
`default_nettype none
module flash_security_margin_commands_test;
    import security_config_reg_cmd_pkg::*;
    localparam int EC = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [63:0] key = 64'h0;
    logic prot = 1'b0;
    logic [2:0] deny = 3'h0;
    logic [1:0] fcfg = 2'h0;
    logic [3:0] dly = 4'h2;
    logic [15:0] rdata;
    logic erase, edone, vfail, vunc, rel, cmpl;
    logic [1:0] pm, dm, xpm, xdm;
    logic [15:0] w [5];
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    security_config_reg_cmd_seq #(.ERASE_CYCLES(EC)) dut_u (.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SEC_CFG_I(8'h00), .STORED_KEY_I(key), .PROTECT_ANY_I(prot),
        .MODE_DENY_I(deny), .ARRAY_ERASE_O(erase), .ERASE_DONE_I(edone), .VERIFY_FAIL_I(vfail),
        .VERIFY_UNCORR_I(vunc), .SECURE_RELEASED_O(rel), .PROG_MARGIN_O(pm), .DATA_MARGIN_O(dm),
        .CMD_COMPLETE_O(cmpl));
    flash_array_model arr_u (.clk_i(clk), .rst_i(rst), .erase_i(erase), .fail_cfg_i(fcfg), .delay_i(dly),
        .done_o(edone), .fail_o(vfail), .unc_o(vunc));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // loads n words, sets the final index, launches and checks the status word
    task automatic run(input int n, input logic [2:0] ix, input logic [15:0] st);
        logic [15:0] d;
        for (int i = 0; i < n; i++) begin
            wr_reg(OFS_IDX, 16'(i));
            wr_reg(OFS_PARAM, w[i]);
        end
        wr_reg(OFS_IDX, {13'h0, ix});
        wr_reg(OFS_STAT, 16'h0080);
        repeat (3) @(posedge clk);
        // no register traffic at all until the command completes
        for (int t = 0; t < 200 && cmpl !== 1'b1; t++) @(posedge clk);
        rd_reg(OFS_STAT, d);
        chk("status", st, d);
    endtask
    function automatic logic [1:0] eff(input logic [1:0] d, input logic [1:0] p);
        return (d != LVL_NORMAL) ? d : p;
    endfunction
    function automatic logic [1:0] lvl(input logic [15:0] s);
        return (s == MRG_USER1) ? LVL_ERASED : (s == MRG_USER0) ? LVL_PROGRAMMED : LVL_NORMAL;
    endfunction
    task automatic margin(input logic b, input logic [15:0] s);
        w[0] = {CMD_MARGIN, 7'h0, b};
        w[1] = s;
        run(2, IDX_MARGIN, (s > 16'h0002) ? 16'h00A0 : 16'h0080);
        if (s <= 16'h0002 && b) xdm = lvl(s);
        if (s <= 16'h0002 && !b) xpm = lvl(s);
        chk("prog margin", {14'h0, xpm}, {14'h0, pm});
        chk("data margin", {14'h0, eff(xdm, xpm)}, {14'h0, dm});
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        xpm = 2'h0;
        xdm = 2'h0;
    endtask
    initial begin
        logic [15:0] d;
        void'($urandom(32'hA7AB));
        key <= {$urandom, $urandom};
        xpm = 2'h0;
        xdm = 2'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_reg(OFS_STAT, d);
        chk("status reset", 16'h0080, d);
        rd_reg(OFS_SEC, d);
        chk("security reset", 16'h0000, d);
        rd_reg(4'hF, d);
        chk("unmapped", 16'h0000, d);
        $display("test reset done");
        margin(1'b1, MRG_USER1);
        margin(1'b0, MRG_USER0);
        margin(1'b1, MRG_NORMAL);
        margin(1'b0, 16'h0003);
        for (int i = 0; i < 10; i++) begin
            margin(1'($urandom), 16'($urandom % 3));
        end
        run(2, 3'h0, 16'h00A0);
        margin(1'b0, MRG_NORMAL);
        $display("test margin done");
        w[1] = 16'h0000;
        wr_reg(OFS_SEC, 16'h0080);
        for (int k = 0; k < 3; k++) begin
            deny <= 3'h1 << k;
            w[0] = {CMD_UNSECURE + 8'(k), 8'h00};
            run(2, (k == 0) ? IDX_UNSECURE : (k == 1) ? IDX_BACKDOOR : IDX_MARGIN, 16'h00A0);
        end
        deny <= 3'h0;
        $display("test mode done");
        w[0] = {CMD_BACKDOOR, 8'h00};
        for (int i = 1; i < 5; i++) begin
            w[i] = key[(i - 1) * 16 +: 16];
        end
        wr_reg(OFS_SEC, 16'h0000);
        run(5, IDX_BACKDOOR, 16'h00A0);
        wr_reg(OFS_SEC, 16'h0080);
        run(5, 3'h3, 16'h00A0);
        w[3] = ~w[3];
        run(5, IDX_BACKDOOR, 16'h00A0);
        w[3] = ~w[3];
        rd_reg(OFS_MARGIN, d);
        chk("lockout", 16'h0080, d & 16'h0080);
        run(5, IDX_BACKDOOR, 16'h00A0);
        chk("locked", 16'h0000, {15'h0, rel});
        do_reset();
        wr_reg(OFS_SEC, 16'h0080);
        run(5, IDX_BACKDOOR, 16'h0080);
        rd_reg(OFS_SEC, d);
        chk("key release", 16'h0081, d);
        rd_reg(OFS_PARAM, d);
        chk("param word", w[4], d);
        $display("test key done");
        do_reset();
        w[0] = {CMD_UNSECURE, 8'h00};
        run(1, 3'h1, 16'h00A0);
        prot <= 1'b1;
        run(1, IDX_UNSECURE, 16'h0090);
        prot <= 1'b0;
        fcfg <= 2'h1;
        run(1, IDX_UNSECURE, 16'h0082);
        fcfg <= 2'h2;
        dly <= 4'h6;
        run(1, IDX_UNSECURE, 16'h0083);
        chk("still locked", 16'h0000, {15'h0, rel});
        fcfg <= 2'h0;
        run(1, IDX_UNSECURE, 16'h0080);
        chk("unsecure release", 16'h0001, {15'h0, rel});
        $display("test unsecure done");
        close_out();
    end
endmodule
`default_nettype wire

/* verif/security_config_reg_cmd_seq_asserts.sv */
// concurrent checks on the sequencer ports
`timescale 1ns/1ns
`default_nettype none
module security_config_reg_cmd_seq_chk #(
    parameter int ERASE_CYCLES = 64
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic PROTECT_ANY_I,
    input wire logic [2:0] MODE_DENY_I,
    input wire logic ARRAY_ERASE_O,
    input wire logic ERASE_DONE_I,
    input wire logic VERIFY_FAIL_I,
    input wire logic VERIFY_UNCORR_I,
    input wire logic SECURE_RELEASED_O,
    input wire logic [1:0] PROG_MARGIN_O,
    input wire logic [1:0] DATA_MARGIN_O,
    input wire logic CMD_COMPLETE_O
);
    import security_config_reg_cmd_pkg::*;
    localparam int ERASE_MAX = ERASE_CYCLES + 2;
    // slack covers eval, verify, done and the one cycle lag of the complete copy
    localparam int BUSY_MAX = ERASE_CYCLES + 16;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    a_erase_not_complete: assert property (
        ARRAY_ERASE_O && $past(ARRAY_ERASE_O) |-> !CMD_COMPLETE_O) else $error("complete during erase");
    a_erase_bounded: assert property (
        $rose(ARRAY_ERASE_O) |-> ##[1:ERASE_MAX] !ARRAY_ERASE_O) else $error("erase overruns");
    a_erase_ends_done: assert property (
        ARRAY_ERASE_O && ERASE_DONE_I |-> ##[1:2] !ARRAY_ERASE_O) else $error("erase ignores done");
    a_erase_allowed: assert property (
        $rose(ARRAY_ERASE_O) |-> !PROTECT_ANY_I && !MODE_DENY_I[0]) else $error("erase not allowed");
    a_fail_keeps_lock: assert property (
        $fell(ARRAY_ERASE_O) && (VERIFY_FAIL_I || VERIFY_UNCORR_I) && !SECURE_RELEASED_O
        |=> !SECURE_RELEASED_O [*4]) else $error("released after failed verify");
    a_pass_releases: assert property (
        $fell(ARRAY_ERASE_O) && !VERIFY_FAIL_I && !VERIFY_UNCORR_I |-> ##[0:4] SECURE_RELEASED_O)
        else $error("passed verify not released");
    a_release_sticky: assert property (
        SECURE_RELEASED_O |=> SECURE_RELEASED_O) else $error("release dropped");
    a_release_in_cmd: assert property (
        $rose(SECURE_RELEASED_O) |-> !CMD_COMPLETE_O) else $error("release outside a command");
    a_margin_in_cmd: assert property (
        $changed(PROG_MARGIN_O) |-> !CMD_COMPLETE_O) else $error("margin change outside a command");
    a_margin_legal: assert property (
        PROG_MARGIN_O != 2'h3 && DATA_MARGIN_O != 2'h3) else $error("illegal margin level");
    a_data_tracks_prog: assert property (
        $changed(PROG_MARGIN_O) && $stable(DATA_MARGIN_O) |-> DATA_MARGIN_O != 2'h0)
        else $error("data reads miss program margin");
    a_busy_bounded: assert property (
        $fell(CMD_COMPLETE_O) |-> ##[1:BUSY_MAX] CMD_COMPLETE_O) else $error("command never completes");
    c_release: cover property ($rose(SECURE_RELEASED_O));
    c_verify_fail: cover property ($fell(ARRAY_ERASE_O) && VERIFY_FAIL_I);
    c_data_margin: cover property ($changed(DATA_MARGIN_O));
endmodule
bind security_config_reg_cmd_seq security_config_reg_cmd_seq_chk #(.ERASE_CYCLES(ERASE_CYCLES)) chk_u (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .PROTECT_ANY_I(PROTECT_ANY_I), .MODE_DENY_I(MODE_DENY_I), .ARRAY_ERASE_O(ARRAY_ERASE_O),
    .ERASE_DONE_I(ERASE_DONE_I), .VERIFY_FAIL_I(VERIFY_FAIL_I), .VERIFY_UNCORR_I(VERIFY_UNCORR_I),
    .SECURE_RELEASED_O(SECURE_RELEASED_O), .PROG_MARGIN_O(PROG_MARGIN_O), .DATA_MARGIN_O(DATA_MARGIN_O),
    .CMD_COMPLETE_O(CMD_COMPLETE_O));
`default_nettype wire
